// ===== core/rtcc_comp_alarm.sv
// Temperature compensation of the clock rate plus second/minute/alarm events.
// Assumes byte register access in the RTC clock domain and count inputs
// from the clock's counter chain on the same clock.
`timescale 1ns/1ns
module rtcc_comp_alarm
  import rtcc_pkg::*;
#(
  parameter int DEPTH  = 128,
  parameter int ADDR_W = 7
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  // Register access
  input  wire logic [15:0]       reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  // Temperature sensor
  input  wire logic [TEMP_W-1:0] die_temp_result_i,
  input  wire logic              temp_done_i,
  // Counter chain
  input  wire logic              second_boundary_i,
  input  wire logic              minute_boundary_i,
  input  wire logic [5:0]        minute_count_i,
  input  wire logic [4:0]        hour_count_i,
  // Rate adjust output
  output rtcc_rate_type          rate_o,
  output logic                   rate_load_o,
  // Events
  output logic                   second_tick_irq_o,
  output logic                   minute_tick_irq_o,
  output logic                   alarm_irq_o,
  output logic                   ext_int6_o
);
  // Elaboration guard: index arithmetic and clamp assume a 128-entry table
  if (DEPTH != 128 || ADDR_W != 7) begin : g_bad_size
    $error("rtcc_comp_alarm: table must be 128 x 8");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] table_index_reg;
  logic              table_index_autoinc_reg;
  logic [7:0]        table_byte_reg;
  logic              table_read_strobe_reg;
  logic              table_write_strobe_reg;
  logic [5:0]        alarm_minute_reg;
  logic [4:0]        alarm_hour_reg;
  logic [7:0]        comp_ctrl_reg;
  logic [TEMP_W-1:0] temp_hold_reg;
  logic              auto_pend_reg;
  logic              match_prev_reg;
  rtcc_state_type    state_reg;
  rtcc_state_type    state_next;
  rtcc_rate_type     rate_reg;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire sel_index  = reg_addr_i == ADDR_TABLE_INDEX_CTRL;
  wire sel_data   = reg_addr_i == ADDR_TABLE_DATA;
  wire sel_strobe = reg_addr_i == ADDR_TABLE_STROBES;
  wire sel_amin   = reg_addr_i == ADDR_ALARM_MIN_TARGET;
  wire sel_ahour  = reg_addr_i == ADDR_ALARM_HOUR_TARGET;
  wire sel_ctrl   = reg_addr_i == ADDR_TEMP_COMP_CONTROL;
  wire comp_enable = comp_ctrl_reg[BIT_COMP_EN];

  // Temperature to table address, shift then clamp
  function automatic logic [ADDR_W-1:0] temp_to_index(input logic [TEMP_W-1:0] t);
    logic signed [8:0] shifted;
    shifted = 9'(signed'(t) >>> SHIFT_PLACES);
    if (shifted < INDEX_MIN)      shifted = INDEX_MIN;
    else if (shifted > INDEX_MAX) shifted = INDEX_MAX;
    return shifted[ADDR_W-1:0];
  endfunction

  // ----------------------------------------------------------------------
  // Arbitration: one table access at a time, software first
  // ----------------------------------------------------------------------
  wire soft_req  = table_read_strobe_reg | table_write_strobe_reg;
  wire soft_go   = (state_reg == ST_IDLE) && soft_req;
  wire auto_go   = (state_reg == ST_IDLE) && !soft_req && auto_pend_reg;
  wire soft_done = state_reg == ST_SOFT;
  wire auto_done = state_reg == ST_AUTO;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (soft_go)      state_next = ST_SOFT;
        else if (auto_go) state_next = ST_AUTO;
      end
      ST_SOFT: state_next = ST_DONE;
      ST_AUTO: state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Memory address shared by both owners
  wire [ADDR_W-1:0] mem_addr = (auto_go || auto_done) ?
                               temp_to_index(temp_hold_reg) : table_index_reg;
  wire              mem_wr   = soft_go && table_write_strobe_reg;
  wire [7:0]        mem_rdata;

  rtcc_table_mem #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) u_table (
    .clock_i   (clock_i),
    .wr_en_i   (mem_wr),
    .addr_i    (mem_addr),
    .wr_data_i (table_byte_reg),
    .rd_data_o (mem_rdata)
  );

  // Sum of nominal rate and sign-extended entry
  wire [SUM_W-1:0] rate_sum = NOMINAL_RATE + {{(SUM_W-8){mem_rdata[7]}}, mem_rdata};

  // ----------------------------------------------------------------------
  // Software writes and hardware strobe clear
  // ----------------------------------------------------------------------
  wire wr_index  = reg_wr_i && sel_index;
  wire wr_strobe = reg_wr_i && sel_strobe;
  wire step_idx  = soft_done && table_index_autoinc_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      table_index_reg         <= RESET_INDEX;
      table_index_autoinc_reg <= 1'b0;
    end else if (wr_index) begin
      table_index_reg         <= reg_wdata_i[ADDR_W-1:0];
      table_index_autoinc_reg <= reg_wdata_i[BIT_AUTOINC];
    end else if (step_idx) begin
      table_index_reg         <= table_index_reg + 7'h01;
    end
  end

  // Data register: software write, or table read result
  always_ff @(posedge clock_i) begin
    if (reset_i)                                  table_byte_reg <= RESET_BYTE;
    else if (soft_done && table_read_strobe_reg)  table_byte_reg <= mem_rdata;
    else if (reg_wr_i && sel_data)                table_byte_reg <= reg_wdata_i;
  end

  // Strobes hold until the access completes; software set wins only when idle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      table_read_strobe_reg  <= 1'b0;
      table_write_strobe_reg <= 1'b0;
    end else if (soft_done) begin
      table_read_strobe_reg  <= 1'b0;
      table_write_strobe_reg <= 1'b0;
    end else if (wr_strobe && !soft_req && state_reg == ST_IDLE) begin
      table_read_strobe_reg  <= reg_wdata_i[BIT_READ_STB];
      table_write_strobe_reg <= reg_wdata_i[BIT_WRITE_STB];
    end
  end

  // Other configuration registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      alarm_minute_reg <= 6'h00;
      alarm_hour_reg   <= 5'h00;
      comp_ctrl_reg    <= RESET_BYTE;
    end else begin
      if (reg_wr_i && sel_amin)  alarm_minute_reg <= reg_wdata_i[5:0];
      if (reg_wr_i && sel_ahour) alarm_hour_reg   <= reg_wdata_i[4:0];
      if (reg_wr_i && sel_ctrl)  comp_ctrl_reg    <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Automatic compensation; no power-state gating, so it runs in all states
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      temp_hold_reg <= '0;
      auto_pend_reg <= 1'b0;
    end else begin
      if (temp_done_i) temp_hold_reg <= die_temp_result_i;
      // New result sets the request over the grant of the previous one
      if (temp_done_i && comp_enable) auto_pend_reg <= 1'b1;
      else if (auto_go)               auto_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg   <= ST_IDLE;
      rate_reg    <= rtcc_rate_type'(NOMINAL_RATE);  // Zero adjustment
      rate_load_o <= 1'b0;
    end else begin
      state_reg   <= state_next;
      rate_load_o <= auto_done;
      if (auto_done) begin
        rate_reg.coarse <= rate_sum[SUM_W-1:FINE_W];
        rate_reg.fine   <= rate_sum[FINE_W-1:0];
      end
    end
  end
  assign rate_o = rate_reg;

  // ----------------------------------------------------------------------
  // Read mux, registered data
  // ----------------------------------------------------------------------
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr_i)
      ADDR_DIE_TEMP_HIGH:     rdata_next = temp_hold_reg[10:3];
      ADDR_DIE_TEMP_LOW:      rdata_next = {temp_hold_reg[2:0], 5'h00};
      ADDR_TABLE_INDEX_CTRL:  rdata_next = {table_index_autoinc_reg, table_index_reg};
      ADDR_TABLE_DATA:        rdata_next = table_byte_reg;
      ADDR_TABLE_STROBES:     rdata_next = {6'h00, table_read_strobe_reg,
                                            table_write_strobe_reg};
      ADDR_ALARM_MIN_TARGET:  rdata_next = {2'h0, alarm_minute_reg};
      ADDR_ALARM_HOUR_TARGET: rdata_next = {3'h0, alarm_hour_reg};
      ADDR_TEMP_COMP_CONTROL: rdata_next = comp_ctrl_reg;
      default:                rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i)       reg_rdata_o <= 8'h00;
    else if (reg_rd_i) reg_rdata_o <= rdata_next;
  end

  // ----------------------------------------------------------------------
  // Events: ticks and alarm, merged onto one line
  // ----------------------------------------------------------------------
  wire alarm_match = (minute_count_i == alarm_minute_reg) &&
                     (hour_count_i == alarm_hour_reg);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      match_prev_reg    <= 1'b1;  // Avoids a false alarm at reset
      second_tick_irq_o <= 1'b0;
      minute_tick_irq_o <= 1'b0;
      alarm_irq_o       <= 1'b0;
    end else begin
      match_prev_reg    <= alarm_match;
      second_tick_irq_o <= second_boundary_i;
      minute_tick_irq_o <= minute_boundary_i;
      alarm_irq_o       <= alarm_match && !match_prev_reg;
    end
  end
  assign ext_int6_o = second_tick_irq_o | minute_tick_irq_o | alarm_irq_o;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_strobe_clears: assert property (@(posedge clock_i) disable iff (reset_i)
    state_reg == ST_SOFT |=> !table_read_strobe_reg && !table_write_strobe_reg)
    else $error("strobe not cleared after access");
  a_strobe_holds: assert property (@(posedge clock_i) disable iff (reset_i)
    soft_go |=> $stable(soft_req))
    else $error("strobe dropped early");
  a_autoinc_step: assert property (@(posedge clock_i) disable iff (reset_i)
    soft_done && table_index_autoinc_reg && !wr_index
    |=> table_index_reg == $past(table_index_reg) + 7'h01)
    else $error("index not incremented");
  a_index_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    soft_done && !table_index_autoinc_reg && !wr_index |=> $stable(table_index_reg))
    else $error("index moved without autoinc");
  a_one_owner: assert property (@(posedge clock_i) disable iff (reset_i)
    !(soft_go && auto_go))
    else $error("two table owners");
  a_comp_update: assert property (@(posedge clock_i) disable iff (reset_i)
    temp_done_i && comp_enable && state_reg == ST_IDLE && !soft_req
    |-> ##[1:8] rate_load_o)
    else $error("no rate update after measurement");
  a_rate_split: assert property (@(posedge clock_i) disable iff (reset_i)
    auto_done |=> {rate_o.coarse, rate_o.fine} == $past(rate_sum))
    else $error("rate fields differ from sum");
  a_index_range: assert property (@(posedge clock_i) disable iff (reset_i)
    auto_done && signed'(temp_hold_reg) > 11'sd255 |-> mem_addr == 7'h3F)
    else $error("index not clamped high");
  a_alarm_once: assert property (@(posedge clock_i) disable iff (reset_i)
    alarm_irq_o |=> !alarm_irq_o)
    else $error("alarm repeated");
  a_shared_line: assert property (@(posedge clock_i) disable iff (reset_i)
    $rose(second_boundary_i) |=> ext_int6_o)
    else $error("second tick missing on line");

  c_soft_write: cover property (@(posedge clock_i) soft_go && table_write_strobe_reg);
  c_soft_read:  cover property (@(posedge clock_i) soft_done && table_read_strobe_reg);
  c_auto_load:  cover property (@(posedge clock_i) rate_load_o);
  c_alarm:      cover property (@(posedge clock_i) alarm_irq_o);
endmodule // rtcc_comp_alarm

// ===== core/rtcc_pkg.sv
// Package for the crystal temperature compensation and tick/alarm block.
// Assumes byte-wide I/O RAM register access from an 8-bit processor core.
package rtcc_pkg;
  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_DIE_TEMP_HIGH     = 16'h2881;
  localparam logic [15:0] ADDR_DIE_TEMP_LOW      = 16'h2882;
  localparam logic [15:0] ADDR_TABLE_INDEX_CTRL  = 16'h2887;
  localparam logic [15:0] ADDR_TABLE_DATA        = 16'h2888;
  localparam logic [15:0] ADDR_TABLE_STROBES     = 16'h2889;
  localparam logic [15:0] ADDR_ALARM_MIN_TARGET  = 16'h289E;
  localparam logic [15:0] ADDR_ALARM_HOUR_TARGET = 16'h289F;
  localparam logic [15:0] ADDR_TEMP_COMP_CONTROL = 16'h28A0;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          BIT_AUTOINC    = 7;
  localparam int          BIT_READ_STB   = 1;
  localparam int          BIT_WRITE_STB  = 0;
  localparam int          BIT_COMP_EN    = 5;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [6:0]  RESET_INDEX    = 7'h00;

  // ----------------------------------------------------------------------
  // Compensation arithmetic
  // ----------------------------------------------------------------------
  localparam int          TEMP_W         = 11;
  localparam int          SHIFT_PLACES   = 2;
  localparam int          SUM_W          = 19;
  localparam int          FINE_W         = 2;
  localparam int          COARSE_W       = 17;
  localparam logic [18:0] NOMINAL_RATE   = 19'h40000;
  localparam logic signed [8:0] INDEX_MIN = -9'sd64;
  localparam logic signed [8:0] INDEX_MAX = 9'sd63;

  // Rate adjust result carried as one struct
  typedef struct packed {
    logic [16:0] coarse;
    logic [1:0]  fine;
  } rtcc_rate_type;

  // Table access owner
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SOFT  = 2'b01,
    ST_AUTO  = 2'b11,
    ST_DONE  = 2'b10
  } rtcc_state_type;
endpackage : rtcc_pkg

// ===== core/rtcc_table_mem.sv
// Lookup memory of signed correction bytes, registered read data.
// Assumes the surrounding battery-backed domain keeps its contents.
`timescale 1ns/1ns
module rtcc_table_mem #(
  parameter int DEPTH  = 128,
  parameter int ADDR_W = 7
) (
  // Clock
  input  wire logic              clock_i,
  // Port
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wr_data_i,
  output logic      [7:0]        rd_data_o
);
  // Elaboration guard: the address must reach every entry and no more
  if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
    $error("rtcc_table_mem: DEPTH must be 2**ADDR_W");
  end

  logic [7:0] store_reg [DEPTH];

  // Read before write, read data always registered; no reset keeps contents
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      store_reg[addr_i] <= wr_data_i;
    end
    rd_data_o <= store_reg[addr_i];
  end
endmodule // rtcc_table_mem

// ===== bench/rtcc_sensor_model.sv
// Behavioural die temperature sensor for the compensation bench.
// Assumes the bench raises req_i for one cycle at a falling clock edge.
`timescale 1ns/1ns
module rtcc_sensor_model
  import rtcc_pkg::*;
(
  // Clock
  input  wire logic              clock_i,
  // Bench request
  input  wire logic              req_i,
  input  wire logic [TEMP_W-1:0] value_i,
  // Sensor side
  output logic      [TEMP_W-1:0] die_temp_result_o,
  output logic                   temp_done_o
);
  // --------------------------------------------------------------
  // Result stands only with done
  // --------------------------------------------------------------
  // Inverted afterwards so a design that fails to latch is caught
  always @(posedge clock_i) begin
    temp_done_o       <= req_i;
    die_temp_result_o <= req_i ? value_i : ~value_i;
  end
endmodule // rtcc_sensor_model

// ===== bench/tb_top.sv
// Self-checking bench for the compensation and tick/alarm block.
// Assumes the package constants and the sensor model beside it.
`timescale 1ns/1ns
module tb_top
  import rtcc_pkg::*;
;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic          clock_i           = 1'b0;
  logic          reset_i           = 1'b1;
  logic [15:0]   reg_addr_i        = '0;
  logic          reg_wr_i          = 1'b0;
  logic          reg_rd_i          = 1'b0;
  logic [7:0]    reg_wdata_i       = '0;
  logic [7:0]    reg_rdata_o;
  logic [10:0]   die_temp_result_i;
  logic          temp_done_i;
  logic          second_boundary_i = 1'b0;
  logic          minute_boundary_i = 1'b0;
  logic [5:0]    minute_count_i    = '0;
  logic [4:0]    hour_count_i      = '0;
  rtcc_rate_type rate_o;
  logic          rate_load_o;
  logic          second_tick_irq_o;
  logic          minute_tick_irq_o;
  logic          alarm_irq_o;
  logic          ext_int6_o;
  logic          sens_req          = 1'b0;
  logic [10:0]   sens_val          = '0;
  logic          rd_mark           = 1'b0;
  logic [7:0]    mem [128];
  logic [7:0]    exp_rd [$];
  logic [18:0]   exp_rate [$];
  logic [3:0]    exp_irq [$];
  int            n_mismatch        = 0;
  int            num_checks        = 0;
  int            cycles            = 0;
  int            seed              = 32'h4079;
  logic [15:0]   regs [8]          = '{ADDR_TABLE_INDEX_CTRL, ADDR_TABLE_DATA,
    ADDR_TABLE_STROBES, ADDR_ALARM_MIN_TARGET, ADDR_ALARM_HOUR_TARGET,
    ADDR_TEMP_COMP_CONTROL, 16'h2880, 16'h28A1};
  logic [10:0]   temps [7]         = '{11'h400, 11'h3FF, 11'h6FF, 11'h0FC,
    11'h100, 11'h000, 11'h7FF};

  always #2 clock_i = ~clock_i;

  rtcc_sensor_model sens_u (.clock_i(clock_i), .req_i(sens_req), .value_i(sens_val),
    .die_temp_result_o(die_temp_result_i), .temp_done_o(temp_done_i));

  rtcc_comp_alarm dut_u (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .die_temp_result_i(die_temp_result_i),
    .temp_done_i(temp_done_i), .second_boundary_i(second_boundary_i),
    .minute_boundary_i(minute_boundary_i), .minute_count_i(minute_count_i),
    .hour_count_i(hour_count_i), .rate_o(rate_o), .rate_load_o(rate_load_o),
    .second_tick_irq_o(second_tick_irq_o), .minute_tick_irq_o(minute_tick_irq_o),
    .alarm_irq_o(alarm_irq_o), .ext_int6_o(ext_int6_o));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(string what, logic [18:0] e, logic [18:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic reg_wr(logic [15:0] a, logic [7:0] d);
    @(negedge clock_i);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask

  // Read data lands on the edge that takes the read
  task automatic reg_rd(logic [15:0] a, output logic [7:0] d, input logic chk);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    rd_mark    = chk;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    rd_mark  = 1'b0;
    d        = reg_rdata_o;
  endtask

  task automatic rd_chk(logic [15:0] a, logic [7:0] e);
    logic [7:0] d;
    exp_rd.push_back(e);
    reg_rd(a, d, 1'b1);
  endtask

  // Strobe then poll, bounded, until hardware clears it
  task automatic tbl(logic [7:0] stb);
    logic [7:0] d;
    reg_wr(ADDR_TABLE_STROBES, stb);
    d = 8'hFF;
    for (int i = 0; i < 20 && d[1:0] !== 2'b00; i++) reg_rd(ADDR_TABLE_STROBES, d, 1'b0);
    check("strobe clear", 19'h0, d[1:0]);
  endtask

  function automatic logic [18:0] exp_rate_f(logic [10:0] t);
    logic signed [8:0] ix;
    logic [7:0]        b;
    ix = 9'($signed(t) >>> 2);
    if (ix < INDEX_MIN) ix = INDEX_MIN;
    if (ix > INDEX_MAX) ix = INDEX_MAX;
    b = mem[ix[6:0]];
    return NOMINAL_RATE + {{11{b[7]}}, b};
  endfunction

  // Fixed wait covers the stated answer plus a software delay
  task automatic temp(logic [10:0] t, logic en);
    if (en) exp_rate.push_back(exp_rate_f(t));
    @(negedge clock_i);
    sens_val = t;
    sens_req = 1'b1;
    @(negedge clock_i);
    sens_req = 1'b0;
    repeat (12) @(negedge clock_i);
    rd_chk(ADDR_DIE_TEMP_HIGH, t[10:3]);
    rd_chk(ADDR_DIE_TEMP_LOW, {t[2:0], 5'h00});
  endtask

  // --------------------------------------------------------------
  // Output watcher: oldest note against each result
  // --------------------------------------------------------------
  always @(posedge clock_i) begin
    #1;
    if (!reset_i && rd_mark)
      check("reg read", exp_rd.size() ? exp_rd.pop_front() : 19'h7FFFF, reg_rdata_o);
    if (!reset_i && rate_load_o)
      check("rate", exp_rate.size() ? exp_rate.pop_front() : 19'h7FFFF, rate_o);
    if (!reset_i && (second_tick_irq_o | minute_tick_irq_o | alarm_irq_o))
      check("irq", exp_irq.size() ? exp_irq.pop_front() : 19'h7FFFF, {ext_int6_o,
        alarm_irq_o, minute_tick_irq_o, second_tick_irq_o});
  end

  // Hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      test_done();
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [6:0] k;
    repeat (20) @(negedge clock_i);
    reset_i = 1'b0;
    check("rate reset", NOMINAL_RATE, rate_o);
    foreach (regs[i]) rd_chk(regs[i], RESET_BYTE);
    // Fill the whole table, index checked halfway
    reg_wr(ADDR_TABLE_INDEX_CTRL, 8'h80);
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'($random(seed));
      reg_wr(ADDR_TABLE_DATA, mem[i]);
      tbl(8'h01);
      if (i == 63) rd_chk(ADDR_TABLE_INDEX_CTRL, 8'hC0);
    end
    rd_chk(ADDR_TABLE_INDEX_CTRL, 8'h80);
    // Reads at both ends and at random with the index held, then one with autoinc
    for (int i = 0; i < 6; i++) begin
      k = (i < 2) ? 7'(i * 127) : 7'($random(seed));
      reg_wr(ADDR_TABLE_INDEX_CTRL, {1'b0, k});
      tbl(8'h02);
      rd_chk(ADDR_TABLE_DATA, mem[k]);
      rd_chk(ADDR_TABLE_INDEX_CTRL, {1'b0, k});
    end
    reg_wr(ADDR_TABLE_INDEX_CTRL, 8'h85);
    tbl(8'h02);
    rd_chk(ADDR_TABLE_DATA, mem[5]);
    rd_chk(ADDR_TABLE_INDEX_CTRL, 8'h86);
    // Both strobes in one access: new byte stored, old byte returned
    k = 7'h06;
    reg_wr(ADDR_TABLE_DATA, 8'h5A);
    tbl(8'h03);
    rd_chk(ADDR_TABLE_DATA, mem[k]);
    mem[k] = 8'h5A;
    rd_chk(ADDR_TABLE_INDEX_CTRL, 8'h87);
    // Compensation over boundaries and random results
    reg_wr(ADDR_TEMP_COMP_CONTROL, 8'h20);
    foreach (temps[i]) temp(temps[i], 1'b1);
    repeat (6) temp(11'($random(seed)), 1'b1);
    // Software read racing an automatic lookup
    fork
      temp(11'h0A4, 1'b1);
      begin
        reg_wr(ADDR_TABLE_INDEX_CTRL, 8'h11);
        tbl(8'h02);
        rd_chk(ADDR_TABLE_DATA, mem[17]);
      end
    join
    // Disabled: no update, temperature result still readable
    reg_wr(ADDR_TEMP_COMP_CONTROL, 8'h00);
    temp(11'h123, 1'b0);
    // Second and minute events, alone and together
    for (int i = 1; i < 4; i++) begin
      exp_irq.push_back({2'b10, 2'(i)});
      @(negedge clock_i);
      {minute_boundary_i, second_boundary_i} = 2'(i);
      @(negedge clock_i);
      {minute_boundary_i, second_boundary_i} = 2'b00;
      repeat (3) @(negedge clock_i);
    end
    // Alarm: partial matches stay quiet, each of the two full matches fires once
    reg_wr(ADDR_ALARM_MIN_TARGET, 8'h05);
    reg_wr(ADDR_ALARM_HOUR_TARGET, 8'h03);
    rd_chk(ADDR_ALARM_MIN_TARGET, 8'h05);
    rd_chk(ADDR_ALARM_HOUR_TARGET, 8'h03);
    for (int i = 0; i < 5; i++) begin
      if (i == 2 || i == 4) exp_irq.push_back(4'hC);
      @(negedge clock_i);
      minute_count_i = (i == 1) ? 6'd4 : (i == 3) ? 6'd6 : 6'd5;
      hour_count_i   = (i == 0) ? 5'd2 : 5'd3;
      repeat (6) @(negedge clock_i);
    end
    check("pending", 19'h0, 19'(exp_rd.size() + exp_rate.size() + exp_irq.size()));
    test_done();
  end
endmodule // tb_top
